/* hw/rcs_pkg.sv */
// Constants, register map and types of the reverse-current and slew configuration bank
package rcs_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 10;
    // Debounce times
    localparam int DB_SHORT_NS = 40;
    localparam int DB_LONG_NS = 200;
    localparam int DB_SHORT_CYC = (DB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DB_LONG_CYC = (DB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Slew time base: one millisecond
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
    // Base slew rate is 4 LSB per ms, so interval = ms >> (code + SLEW_BASE_SHIFT)
    localparam int SLEW_BASE_SHIFT = 2;
    // Re-enable delay, no figure given
    localparam int REEN_CYCLES_DFLT = 1000;
    // Bus
    localparam int AXI_AW = 18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_ACTION_CFG = 16'hFE83;
    localparam logic [15:0] IDX_REV_A = 16'hFE84;
    localparam logic [15:0] IDX_REV_B = 16'hFE85;
    localparam logic [15:0] IDX_SLEW_A = 16'hFE86;
    localparam logic [15:0] IDX_SLEW_B = 16'hFE87;
    localparam logic [15:0] IDX_IRQ_STS = 16'hFE90;
    localparam logic [15:0] IDX_IRQ_MSK = 16'hFE91;
    localparam logic [15:0] IDX_LIVE = 16'hFE92;
    // Reset values
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [3:0] RST_IRQ = 4'h0;
    // Reverse setup fields
    localparam int REV_DB_BIT = 3;
    localparam int REV_THR_LSB = 0;
    // Slew setup fields
    localparam int SLEW_EN_BIT = 0;
    localparam int SLEW_RATE_LSB = 1;
    // Action config fields
    localparam int ACT_A_AFTER_LSB = 0;
    localparam int ACT_A_TRIP_LSB = 2;
    localparam int ACT_B_AFTER_LSB = 4;
    localparam int ACT_B_TRIP_LSB = 6;
    // Trip action codes
    localparam logic [1:0] TRIP_NONE = 2'h0;
    localparam logic [1:0] TRIP_DIS_A = 2'h1;
    localparam logic [1:0] TRIP_DIS_B = 2'h2;
    localparam logic [1:0] TRIP_DIS_ALL = 2'h3;
    // After-clear codes
    localparam logic [1:0] AFTER_DELAY_SS = 2'h0;
    localparam logic [1:0] AFTER_IMMED = 2'h1;
    // Status bits
    localparam int STS_TRIP_A = 0;
    localparam int STS_TRIP_B = 1;
    localparam int STS_CLR_A = 2;
    localparam int STS_CLR_B = 3;
    // Trip thresholds in mV
    localparam logic signed [11:0] THR_010 = -12'sd10;
    localparam logic signed [11:0] THR_011 = -12'sd13;
    localparam logic signed [11:0] THR_100 = -12'sd17;
    localparam logic signed [11:0] THR_101 = -12'sd20;
    localparam logic signed [11:0] THR_110 = -12'sd24;
    localparam logic signed [11:0] THR_111 = -12'sd27;

    typedef enum logic [1:0] {REC_IDLE, REC_TRIPPED, REC_DELAY, REC_WAIT_PON} rcs_rec_t;

    function automatic logic signed [11:0] rcs_thr(input logic [2:0] code);
        case (code)
            3'h2: rcs_thr = THR_010;
            3'h3: rcs_thr = THR_011;
            3'h4: rcs_thr = THR_100;
            3'h5: rcs_thr = THR_101;
            3'h6: rcs_thr = THR_110;
            3'h7: rcs_thr = THR_111;
            default: rcs_thr = 12'sh000;
        endcase
    endfunction
endpackage

/* hw/rcs_slew.sv */
// Output voltage setpoint ramp for one channel
`timescale 1ns/1ns
module rcs_slew
    import rcs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DFLT
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic enable,
    input wire logic [2:0] rate_code,
    // Target and ramped setpoint
    input wire logic [15:0] target,
    output logic [15:0] setpoint,
    output logic busy
);
    typedef struct packed {
        logic [15:0] setpoint;
        logic [23:0] tick;
    } rcs_slew_st_t;

    rcs_slew_st_t st_r;
    rcs_slew_st_t st_nxt;
    logic [23:0] interval;
    logic [23:0] raw_interval;

    assign raw_interval = 24'(MS_CYCLES >> (32'(rate_code) + SLEW_BASE_SHIFT));
    assign interval = (raw_interval == 24'h000000) ? 24'h000001 : raw_interval;

    always_comb
    begin
        st_nxt = st_r;
        if (!enable)
        begin
            st_nxt.setpoint = target;
            st_nxt.tick = 24'h000000;
        end
        else if (st_r.setpoint == target)
        begin
            st_nxt.tick = 24'h000000;
        end
        else if (st_r.tick >= interval - 24'h000001)
        begin
            st_nxt.tick = 24'h000000;
            if (target > st_r.setpoint)
                st_nxt.setpoint = st_r.setpoint + 16'h0001;
            else
                st_nxt.setpoint = st_r.setpoint - 16'h0001;
        end
        else
        begin
            st_nxt.tick = st_r.tick + 24'h000001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign setpoint = st_r.setpoint;
    assign busy = enable && (st_r.setpoint != target);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_slew_interval: assert property (enable && $past(enable)
        && $changed(st_r.setpoint) |-> $past(st_r.tick) == interval - 24'h000001)
        else $error("slew step came at the wrong tick");

    chk_slew_step: assert property (enable && st_r.setpoint != target
        |=> st_r.setpoint == $past(st_r.setpoint)
            || st_r.setpoint == $past(st_r.setpoint) + 16'h0001
            || st_r.setpoint == $past(st_r.setpoint) - 16'h0001)
        else $error("ramp jumped by more than one LSB");

    chk_slew_bypass: assert property (!enable |=> st_r.setpoint == $past(target))
        else $error("setpoint did not follow target with slew off");
endmodule

/* hw/rcs_top.sv */
// Reverse-current protection and voltage slew configuration bank with AXI4-Lite access
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module rcs_top
    import rcs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DFLT,
    parameter int REEN_CYCLES = REEN_CYCLES_DFLT
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sensed power stage
    input wire logic signed [11:0] secondary_current_sense_a,
    input wire logic signed [11:0] secondary_current_sense_b,
    input wire logic power_on_request,
    // Voltage targets and ramped setpoints
    input wire logic [15:0] vout_target_a,
    input wire logic [15:0] vout_target_b,
    output logic [15:0] vout_setpoint_a,
    output logic [15:0] vout_setpoint_b,
    // Output control
    output logic reverse_flag_a,
    output logic reverse_flag_b,
    output logic pwm_enable_a,
    output logic pwm_enable_b,
    output logic pwm_enable_c,
    output logic soft_start_req,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] act;
        logic [1:0][7:0] rev;
        logic [1:0][7:0] slew;
        logic [3:0] sts;
        logic [3:0] msk;
        logic aw_got;
        logic [AXI_AW-1:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [1:0] flag;
        logic [1:0][4:0] db_cnt;
        rcs_rec_t [1:0] rec;
        logic [1:0][1:0] cap;
        logic [1:0][15:0] dly;
        logic [2:0] pwm_en;
        logic ss;
    } rcs_st_t;

    rcs_st_t st_r;
    rcs_st_t st_nxt;
    logic [1:0] below;
    logic [1:0] thr_ok;
    logic signed [1:0][11:0] sense;
    logic [1:0][15:0] target;
    logic [1:0][15:0] setpoint;
    logic [15:0] w_idx;
    logic [15:0] r_idx;
    logic [3:0] ev;
    logic [4:0] limit;
    logic [1:0] trip;
    logic [1:0] after;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    assign sense[0] = secondary_current_sense_a;
    assign sense[1] = secondary_current_sense_b;
    assign target[0] = vout_target_a;
    assign target[1] = vout_target_b;
    assign w_idx = st_r.aw_addr[AXI_AW-1:2];
    assign r_idx = s_axi_araddr[AXI_AW-1:2];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_ch
            assign thr_ok[g] = st_r.rev[g][REV_THR_LSB+2:REV_THR_LSB+1] != 2'h0;
            assign below[g] = thr_ok[g]
                && ($signed(sense[g]) < rcs_thr(st_r.rev[g][REV_THR_LSB+2:REV_THR_LSB]));
            rcs_slew #(
                .MS_CYCLES(MS_CYCLES)
            ) u_slew (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .enable(st_r.slew[g][SLEW_EN_BIT]),
                .rate_code(st_r.slew[g][SLEW_RATE_LSB+2:SLEW_RATE_LSB]),
                .target(target[g]),
                .setpoint(setpoint[g]),
                .busy()
            );
        end
    endgenerate

    always_comb
    begin
        rd_hit = 1'b1;
        case (r_idx)
            IDX_ACTION_CFG: rd_val = st_r.act;
            IDX_REV_A: rd_val = st_r.rev[0];
            IDX_REV_B: rd_val = st_r.rev[1];
            IDX_SLEW_A: rd_val = st_r.slew[0];
            IDX_SLEW_B: rd_val = st_r.slew[1];
            IDX_IRQ_STS: rd_val = {4'h0, st_r.sts};
            IDX_IRQ_MSK: rd_val = {4'h0, st_r.msk};
            IDX_LIVE: rd_val = {3'h0, st_r.pwm_en, st_r.flag};
            default:
            begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        case (w_idx)
            IDX_ACTION_CFG, IDX_REV_A, IDX_REV_B, IDX_SLEW_A, IDX_SLEW_B,
            IDX_IRQ_STS, IDX_IRQ_MSK, IDX_LIVE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        ev = 4'h0;
        limit = 5'h00;
        trip = 2'h0;
        after = 2'h0;
        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata[7:0];
            st_nxt.w_strb0 = s_axi_wstrb[0];
        end
        if (st_r.aw_got && st_r.w_got)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (st_r.w_strb0)
            begin
                case (w_idx)
                    IDX_ACTION_CFG: st_nxt.act = st_r.w_data;
                    IDX_REV_A: st_nxt.rev[0] = st_r.w_data;
                    IDX_REV_B: st_nxt.rev[1] = st_r.w_data;
                    IDX_SLEW_A: st_nxt.slew[0] = st_r.w_data;
                    IDX_SLEW_B: st_nxt.slew[1] = st_r.w_data;
                    IDX_IRQ_STS: st_nxt.sts = st_r.sts & ~st_r.w_data[3:0];
                    IDX_IRQ_MSK: st_nxt.msk = st_r.w_data[3:0];
                    default: st_nxt.bresp = st_nxt.bresp;
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        // Read
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_val;
            st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.ss = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            limit = st_r.rev[c][REV_DB_BIT] ? 5'(DB_LONG_CYC) : 5'(DB_SHORT_CYC);
            if (!thr_ok[c])
            begin
                st_nxt.flag[c] = 1'b0;
                st_nxt.db_cnt[c] = 5'h00;
            end
            else if (below[c] != st_r.flag[c])
            begin
                if (st_r.db_cnt[c] + 5'h01 >= limit)
                begin
                    st_nxt.flag[c] = below[c];
                    st_nxt.db_cnt[c] = 5'h00;
                    ev[c + (below[c] ? 0 : 2)] = 1'b1;
                end
                else
                begin
                    st_nxt.db_cnt[c] = st_r.db_cnt[c] + 5'h01;
                end
            end
            else
            begin
                st_nxt.db_cnt[c] = 5'h00;
            end
            trip = (c == 0) ? st_r.act[ACT_A_TRIP_LSB+:2] : st_r.act[ACT_B_TRIP_LSB+:2];
            after = (c == 0) ? st_r.act[ACT_A_AFTER_LSB+:2] : st_r.act[ACT_B_AFTER_LSB+:2];
            case (st_r.rec[c])
                REC_IDLE:
                begin
                    if (st_r.flag[c] && trip != TRIP_NONE)
                    begin
                        st_nxt.rec[c] = REC_TRIPPED;
                        st_nxt.cap[c] = trip;
                    end
                end
                REC_TRIPPED:
                begin
                    if (!st_r.flag[c])
                    begin
                        st_nxt.dly[c] = 16'h0000;
                        if (after == AFTER_DELAY_SS)
                            st_nxt.rec[c] = REC_DELAY;
                        else if (after == AFTER_IMMED)
                            st_nxt.rec[c] = REC_IDLE;
                        else
                            st_nxt.rec[c] = REC_WAIT_PON;
                    end
                end
                REC_DELAY:
                begin
                    if (st_r.flag[c])
                        st_nxt.rec[c] = REC_TRIPPED;
                    else if (st_r.dly[c] >= 16'(REEN_CYCLES - 1))
                    begin
                        st_nxt.rec[c] = REC_IDLE;
                        st_nxt.ss = 1'b1;
                    end
                    else
                        st_nxt.dly[c] = st_r.dly[c] + 16'h0001;
                end
                REC_WAIT_PON:
                begin
                    if (st_r.flag[c])
                        st_nxt.rec[c] = REC_TRIPPED;
                    else if (power_on_request)
                    begin
                        st_nxt.rec[c] = REC_IDLE;
                        st_nxt.ss = 1'b1;
                    end
                end
                default: st_nxt.rec[c] = REC_IDLE;
            endcase
        end
        st_nxt.pwm_en = 3'h7;
        for (int c = 0; c < 2; c++)
        begin
            if (st_nxt.rec[c] != REC_IDLE)
            begin
                if (st_nxt.cap[c] == TRIP_DIS_A || st_nxt.cap[c] == TRIP_DIS_ALL)
                    st_nxt.pwm_en[0] = 1'b0;
                if (st_nxt.cap[c] == TRIP_DIS_B || st_nxt.cap[c] == TRIP_DIS_ALL)
                    st_nxt.pwm_en[1] = 1'b0;
                if (st_nxt.cap[c] == TRIP_DIS_ALL)
                    st_nxt.pwm_en[2] = 1'b0;
            end
        end
        // Events win over a same-cycle clear
        st_nxt.sts = st_nxt.sts | ev;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.act <= RST_CFG;
            st_r.rev <= {RST_CFG, RST_CFG};
            st_r.slew <= {RST_CFG, RST_CFG};
            st_r.sts <= RST_IRQ;
            st_r.msk <= RST_IRQ;
            st_r.pwm_en <= 3'h7;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign s_axi_rresp = st_r.rresp;
    assign vout_setpoint_a = setpoint[0];
    assign vout_setpoint_b = setpoint[1];
    assign reverse_flag_a = st_r.flag[0];
    assign reverse_flag_b = st_r.flag[1];
    assign pwm_enable_a = st_r.pwm_en[0];
    assign pwm_enable_b = st_r.pwm_en[1];
    assign pwm_enable_c = st_r.pwm_en[2];
    assign soft_start_req = st_r.ss;
    assign irq = |(st_r.sts & st_r.msk);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_below_b_short;
        (below[1] && !st_r.rev[1][REV_DB_BIT] && $stable(st_r.rev[1]))[*5];
    endsequence

    chk_db_short: assert property ($rose(st_r.flag[0]) && !st_r.rev[0][REV_DB_BIT]
        && $stable(st_r.rev[0]) |-> $past(below[0], 4) && !$past(below[0], 5))
        else $error("short debounce length wrong");

    chk_db_long: assert property ($rose(st_r.flag[1]) && st_r.rev[1][REV_DB_BIT]
        && $stable(st_r.rev[1]) |-> $past(below[1], 20))
        else $error("long debounce too short");

    chk_thr_raise: assert property (s_below_b_short |-> st_r.flag[1])
        else $error("flag not raised after sustained low reading");

    chk_thr_decode: assert property (st_r.rev[0][2:0] == 3'h4 && sense[0] == -12'sd17
        |-> !below[0])
        else $error("threshold code 100 not at -17 mV");

    chk_slew_reg: assert property ($rose(st_r.bvalid) && $past(w_idx) == IDX_SLEW_B
        && $past(st_r.w_strb0) |-> st_r.slew[1] == $past(st_r.w_data))
        else $error("slew register B not written");

    chk_trip_all: assert property (st_r.rec[0] == REC_TRIPPED
        && st_r.cap[0] == TRIP_DIS_ALL |-> !pwm_enable_a && !pwm_enable_b && !pwm_enable_c)
        else $error("disable-all trip left outputs on");

    chk_imm_reen: assert property (st_r.rec[0] == REC_TRIPPED && !st_r.flag[0]
        && st_r.act[ACT_A_AFTER_LSB+:2] == AFTER_IMMED |=> st_r.rec[0] == REC_IDLE)
        else $error("immediate re-enable did not happen");

    chk_rsv_code: assert property ($past(st_r.rev[1][2:1]) == 2'h0 |-> !st_r.flag[1])
        else $error("flag raised with reserved threshold");

    chk_irq_level: assert property (st_r.sts[STS_TRIP_B] && st_r.msk[STS_TRIP_B] |-> irq)
        else $error("unmasked status did not raise interrupt");
endmodule

/* bench/rcs_stage_model.sv */
// Sensed power stage model: current sense, power-on request and voltage targets
`timescale 1ns/1ns
module rcs_stage_model
(
    // Clock
    input wire logic ref_clk,
    // Stage outputs
    output logic signed [11:0] sense_a,
    output logic signed [11:0] sense_b,
    output logic pon,
    output logic [15:0] tgt_a,
    output logic [15:0] tgt_b
);
    initial {sense_a, sense_b, pon, tgt_a, tgt_b} = '0;
    task automatic set(input int a, input int b, input logic p);
        @(posedge ref_clk);
        sense_a <= 12'(a);
        sense_b <= 12'(b);
        pon <= p;
    endtask
    task automatic tgt(input logic [15:0] a, input logic [15:0] b);
        @(posedge ref_clk);
        tgt_a <= a;
        tgt_b <= b;
    endtask
endmodule

/* bench/rcs_top_tb.sv */
// Testbench of the reverse-current and slew configuration bank
`timescale 1ns/1ns
module rcs_top_tb;
    import rcs_pkg::*;
    localparam int MS = 1024;
    localparam int REEN = 8;
    logic ref_clk = 0;
    logic rst_n = 0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rdv, v, seed = 32'hDC4D;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, ssr, pon, ss;
    logic [1:0] bresp, rresp, rsp, flg;
    logic [2:0] pwm;
    logic [3:0] wstrb = 4'hF, st = 4'hF;
    logic [15:0] spa, spb, ta, tb2, base;
    logic signed [11:0] sa, sb;
    logic [7:0] regs [logic [15:0]];
    logic [15:0] cfg [5] = '{IDX_ACTION_CFG, IDX_REV_A, IDX_REV_B, IDX_SLEW_A, IDX_SLEW_B};
    int thr [8] = '{0, 0, -10, -13, -17, -20, -24, -27};
    logic [2:0] act [4] = '{3'h7, 3'h6, 3'h5, 3'h0};
    logic [2:0] rec [3] = '{3'h7, 3'h2, 3'h4};
    int mismatches = 0, cmp_count = 0, cyc = 0, k;
    always #5 ref_clk = ~ref_clk;
    rcs_stage_model stage (.ref_clk(ref_clk), .sense_a(sa), .sense_b(sb), .pon(pon),
        .tgt_a(ta), .tgt_b(tb2));
    rcs_top #(.MS_CYCLES(MS), .REEN_CYCLES(REEN)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .secondary_current_sense_a(sa),
        .secondary_current_sense_b(sb), .power_on_request(pon), .vout_target_a(ta),
        .vout_target_b(tb2), .vout_setpoint_a(spa), .vout_setpoint_b(spb),
        .reverse_flag_a(flg[0]), .reverse_flag_b(flg[1]), .pwm_enable_a(pwm[0]),
        .pwm_enable_b(pwm[1]), .pwm_enable_c(pwm[2]), .soft_start_req(ssr), .irq(irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= st;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        rsp = bresp;
        if (st[0] && regs.exists(idx)) regs[idx] = d;
    endtask
    task automatic rd(input logic [15:0] idx);
        @(posedge ref_clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        rsp = rresp;
        rdv = rdata;
    endtask
    task automatic meas();
        k = 0;
        ss = 0;
        while (pwm !== 3'h7 && k < 40)
        begin
            @(posedge ref_clk);
            k++;
            ss |= ssr;
        end
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        foreach (cfg[i]) regs[cfg[i]] = 8'h00;
        tick(2);
        rst_n <= 1;
        foreach (cfg[i])
        begin
            rd(cfg[i]);
            check({rsp, rdv}, {RESP_OKAY, 24'h0, regs[cfg[i]]});
            v = rnd();
            wr(cfg[i], v[7:0]);
        end
        st = 4'h0;
        wr(IDX_REV_A, 8'h5A);
        st = 4'hF;
        foreach (cfg[i])
        begin
            rd(cfg[i]);
            check(rdv, {24'h0, regs[cfg[i]]});
            wr(cfg[i], 8'h00);
        end
        wr(16'h0100, 8'hFF);
        check(rsp, RESP_SLVERR);
        rd(16'h0100);
        check({rsp, rdv}, {RESP_SLVERR, 32'h0});
        $display("test registers done");
        for (int c = 0; c < 8; c++)
        begin
            k = c[0] ? DB_LONG_CYC : DB_SHORT_CYC;
            wr(IDX_REV_A, {4'h0, c[0], c[2:0]});
            wr(IDX_REV_B, {4'h0, c[0], c[2:0]});
            stage.set(thr[c], thr[c] - 1, 1'b0);
            tick(k - 1);
            check(flg, 2'h0);
            tick(4);
            check(flg, {c > 1, 1'b0});
            stage.set(0, 0, 1'b0);
            tick(k + 4);
            check(flg, 2'h0);
        end
        rd(IDX_IRQ_STS);
        check({rdv, irq}, {32'hA, 1'b0});
        wr(IDX_IRQ_MSK, 8'h02);
        tick(1);
        check(irq, 1'b1);
        wr(IDX_IRQ_STS, 8'h0A);
        tick(1);
        rd(IDX_IRQ_STS);
        check({rdv, irq}, 33'h0);
        wr(IDX_IRQ_MSK, 8'h00);
        $display("test thresholds done");
        wr(IDX_REV_A, 8'h07);
        for (int t = 0; t < 4; t++)
        begin
            wr(IDX_ACTION_CFG, 8'(t * 4 + 1));
            stage.set(-40, 0, 1'b0);
            tick(8);
            check(pwm, act[t]);
            stage.set(0, 0, 1'b0);
            meas();
            check(k < 40, 1'b1);
        end
        for (int a = 0; a < 3; a++)
        begin
            wr(IDX_ACTION_CFG, 8'(12 + a));
            stage.set(-40, 0, 1'b0);
            tick(8);
            stage.set(0, 0, 1'b0);
            meas();
            check({k > REEN, k < 40, ss}, rec[a]);
        end
        stage.set(0, 0, 1'b1);
        meas();
        check({k < 40, ss}, 2'h3);
        stage.set(0, 0, 1'b0);
        $display("test actions done");
        wr(IDX_ACTION_CFG, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(IDX_SLEW_A, 8'h00);
            tick(2);
            check(spa, ta);
            wr(IDX_SLEW_A, 8'(c * 2 + 1));
            base = ta;
            v = rnd();
            stage.tgt(base + 16'h8, v[15:0]);
            tick(3 * (MS >> (c + 2)));
            check({((spa - base) inside {2, 3}), spb}, {1'b1, v[15:0]});
        end
        $display("test slew done");
        finish_test();
    end
endmodule
